// >>> core/fcrx_deser.sv
// Purpose: Assemble serial bits into 20-bit words and align on commas.
// Assumes: One bit per clock while run is high.
// Notes:   Earliest bit of a word lands in bit 0.
`timescale 1ns/1ps
module fcrx_deser
	import fcrx_pkg::*;
(
	// Clock and reset
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	// Carrier
	fcrx_deser_if.core  d
);

	logic [WORD_W-1:0] shreg;
	logic [WORD_W-1:0] next_shreg;
	logic              head_seen;

	assign next_shreg = {d.serial_bit, shreg[WORD_W-1:1]};
	assign head_seen  = (next_shreg[WORD_W-1:WORD_W-7] == COMMA_HEAD);

	// ----------------------------------------------------------------
	// Shift and count
	// ----------------------------------------------------------------
	// Count is forced to seven on a comma so its head opens byte 0.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shreg       <= '0;
			d.bit_count <= '0;
			d.comma_hit <= 1'b0;
		end else if (d.run) begin
			shreg       <= next_shreg;
			d.comma_hit <= head_seen && d.align_allowed;
			if (head_seen && d.align_allowed) begin
				d.bit_count <= COMMA_RESUME_CNT;
			end else if (d.bit_count == WORD_LAST_CNT) begin
				d.bit_count <= '0;
			end else begin
				d.bit_count <= d.bit_count + 5'h01;
			end
		end else begin
			d.comma_hit <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Word output and byte clocks
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			d.word       <= '0;
			d.word_valid <= 1'b0;
		end else begin
			d.word_valid <= d.run && (d.bit_count == WORD_LAST_CNT) && !(head_seen && d.align_allowed);
			if (d.run && (d.bit_count == WORD_LAST_CNT)) begin
				d.word <= next_shreg;
			end
		end
	end

	assign d.byte_clks[0] = (d.bit_count <= BYTE0_LAST_CNT);
	assign d.byte_clks[1] = !d.byte_clks[0];

	sequence comma_arrives;
		!rst_i && d.run && d.align_allowed && head_seen;
	endsequence

	chk_align_restart: assert property (@(posedge clk_i) disable iff (rst_i)
		comma_arrives |=> (d.bit_count == COMMA_RESUME_CNT) && d.comma_hit)
		else $error("Comma did not restart the bit count at seven.");

	chk_no_align_off: assert property (@(posedge clk_i) disable iff (rst_i)
		(!rst_i && d.run && !d.align_allowed && d.bit_count != WORD_LAST_CNT)
		|=> (d.bit_count == $past(d.bit_count) + 5'h01) && !d.comma_hit)
		else $error("Count was disturbed while alignment was off.");

endmodule

// >>> core/fcrx_deser_if.sv
// Purpose: Carrier between the control top and the word assembler.
// Assumes: Both ends share clk_i.
// Notes:   ctrl drives the serial bit and permissions; core answers.
`timescale 1ns/1ps
interface fcrx_deser_if;
	logic        serial_bit;
	logic        run;
	logic        align_allowed;
	logic [19:0] word;
	logic        word_valid;
	logic        comma_hit;
	logic [4:0]  bit_count;
	logic [1:0]  byte_clks;

	modport core (
		input  serial_bit, run, align_allowed,
		output word, word_valid, comma_hit, bit_count, byte_clks
	);
	modport ctrl (
		output serial_bit, run, align_allowed,
		input  word, word_valid, comma_hit, bit_count, byte_clks
	);
endinterface

// >>> core/fcrx_pkg.sv
// Purpose: Shared constants of the receive comma-lock control block.
// Assumes: One 50 MHz clock; one serial bit is presented per clock.
// Notes:   Register offsets are Wishbone byte addresses.
package fcrx_pkg;

	// ----------------------------------------------------------------
	// Word framing
	// ----------------------------------------------------------------
	localparam int             WORD_W           = 20;
	localparam int             BYTE_W           = 10;
	localparam int             CNT_W            = 5;
	localparam logic [6:0]     COMMA_HEAD       = 7'h7C;
	localparam logic [4:0]     COMMA_RESUME_CNT = 5'h07;
	localparam logic [4:0]     BYTE0_LAST_CNT   = 5'h09;
	localparam logic [4:0]     WORD_LAST_CNT    = 5'h13;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int             CLK_MHZ          = 50;
	localparam int             REF_CLK_KHZ      = 53125;
	localparam logic [2:0]     LOSS_REF_EDGES   = 3'h4;
	localparam int             POR_HOLD_US      = 10;
	localparam int             POR_HOLD_CYC     = POR_HOLD_US * CLK_MHZ;
	localparam int             LOCK_DWELL_US    = 500;
	localparam int             LOCK_DWELL_CYC   = LOCK_DWELL_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]     ADR_CTRL         = 8'h00;
	localparam logic [7:0]     ADR_STATUS       = 8'h04;
	localparam logic [7:0]     ADR_IRQ_STAT     = 8'h08;
	localparam logic [7:0]     ADR_IRQ_MASK     = 8'h0C;
	localparam logic [7:0]     ADR_RX_WORD      = 8'h10;
	localparam int             CTRL_RX_EN_BIT   = 0;
	localparam logic           CTRL_RX_EN_RST   = 1'b1;
	localparam int             ST_ALIGNED       = 0;
	localparam int             ST_LOSS          = 1;
	localparam int             ST_PLL_REF       = 2;
	localparam int             ST_DWELL_DONE    = 3;
	localparam int             ST_POR_N         = 4;
	localparam int             ST_LOOPBACK      = 5;
	localparam int             ST_EQ_ON         = 6;
	localparam int             IRQ_W            = 4;
	localparam int             IRQ_COMMA        = 0;
	localparam int             IRQ_LOSS_SET     = 1;
	localparam int             IRQ_LOSS_CLR     = 2;
	localparam int             IRQ_WORD         = 3;
	localparam logic [3:0]     IRQ_MASK_RST     = 4'h0;

endpackage

// >>> core/fcrx_top.sv
// Purpose: Receive-side serial input select, comma lock, loss and reset control.
// Assumes: Serial inputs and the reference clock are sampled on clk_i.
// Notes:   Registers sit on a classic Wishbone slave with one interrupt line.
//
// Overview of operation
// - The 53.125 MHz reference clock is the recovery PLL target while lock-to-reference is asked.
// - A positive-disparity K28.5 comma raises comma-found, only while alignment is enabled.
// - With alignment enabled, a comma starting 0011111 restarts the byte clocks and registers.
// - With alignment disabled, commas disturb nothing and comma-found stays low.
// - While lock-to-reference is low, comma detection and alignment are off entirely.
// - Loopback select high takes the wrap port, low takes the cable input.
// - The cable equalizer is on while its active-low enable is low and loopback select is low.
// - Lock-to-reference low steers the PLL onto the reference clock instead of data.
// - Both loss outputs rise on low amplitude or no transition within 4 reference cycles.
// - The active-low power-on reset stays asserted until the supply has been good for POR_HOLD_CYCLES clocks.
// - Two 10-bit bytes are presented, byte 0 in bits 0 to 9 holding the earlier bits.
// - Two byte clocks 180 degrees apart are derived from the received data.
`timescale 1ns/1ps
module fcrx_top
	import fcrx_pkg::*;
#(
	parameter int LOCK_DWELL_CYCLES = LOCK_DWELL_CYC,
	parameter int POR_HOLD_CYCLES   = POR_HOLD_CYC
)(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Serial inputs and pin controls
	input  wire logic        cable_serial_in_i,
	input  wire logic        wrap_serial_in_i,
	input  wire logic        loopback_select_i,
	input  wire logic        equalizer_on_n_i,
	input  wire logic        lock_to_reference_n_i,
	input  wire logic        comma_align_enable_i,
	input  wire logic        receive_reference_clock_i,
	input  wire logic        amplitude_low_i,
	input  wire logic        supply_good_i,
	// Receive outputs
	output logic [19:0]      rx_data_o,
	output logic [1:0]       recovered_byte_clocks_o,
	output logic             comma_found_out_o,
	output logic             signal_loss_a_o,
	output logic             signal_loss_b_o,
	output logic             power_on_reset_n_o,
	output logic             pll_ref_select_o,
	output logic             equalizer_active_o,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Interrupt
	output logic             irq_o
);

	fcrx_deser_if dif ();

	logic             rx_enable;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic             sel_bit;
	logic             prev_bit;
	logic             ref_prev;
	logic [2:0]       quiet_edges;
	logic             aligned;
	logic [15:0]      dwell_cnt;
	logic             dwell_done;
	logic [15:0]      por_cnt;
	logic             loss_now;
	logic             loss_prev;
	logic             wb_req;
	logic             wb_wr;

	// ----------------------------------------------------------------
	// Input select and analog steering
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_bit            <= 1'b0;
			prev_bit           <= 1'b0;
			pll_ref_select_o   <= 1'b0;
			equalizer_active_o <= 1'b0;
		end else begin
			sel_bit            <= loopback_select_i ? wrap_serial_in_i : cable_serial_in_i;
			prev_bit           <= sel_bit;
			pll_ref_select_o   <= !lock_to_reference_n_i;
			equalizer_active_o <= !equalizer_on_n_i && !loopback_select_i;
		end
	end

	assign dif.serial_bit    = sel_bit;
	assign dif.run           = rx_enable;
	assign dif.align_allowed = comma_align_enable_i && lock_to_reference_n_i;

	fcrx_deser u_deser (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d     (dif)
	);

	// ----------------------------------------------------------------
	// Parallel outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_data_o               <= '0;
			recovered_byte_clocks_o <= 2'h1;
			comma_found_out_o       <= 1'b0;
		end else begin
			if (dif.word_valid) begin
				rx_data_o <= dif.word;
			end
			recovered_byte_clocks_o <= dif.byte_clks;
			comma_found_out_o       <= dif.comma_hit && dif.align_allowed;
		end
	end

	// ----------------------------------------------------------------
	// Loss of signal
	// ----------------------------------------------------------------
	// The reference pin is sampled, so it must stay well below half clk_i.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_prev    <= 1'b0;
			quiet_edges <= '0;
		end else begin
			ref_prev <= receive_reference_clock_i;
			if (sel_bit != prev_bit) begin
				quiet_edges <= '0;
			end else if (receive_reference_clock_i && !ref_prev
			             && quiet_edges != LOSS_REF_EDGES) begin
				quiet_edges <= quiet_edges + 3'h1;
			end
		end
	end

	assign loss_now = amplitude_low_i || (quiet_edges == LOSS_REF_EDGES);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			signal_loss_a_o <= 1'b0;
			signal_loss_b_o <= 1'b0;
			loss_prev       <= 1'b0;
		end else begin
			signal_loss_a_o <= loss_now;
			signal_loss_b_o <= loss_now;
			loss_prev       <= signal_loss_a_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aligned <= 1'b0;
		end else if (dif.comma_hit) begin
			aligned <= 1'b1;
		end else if (signal_loss_a_o || !lock_to_reference_n_i) begin
			aligned <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Reference dwell and power-on reset
	// ----------------------------------------------------------------
	// Dwell is reported only; holding the pin long enough is the host's task.
	always_ff @(posedge clk_i) begin
		if (rst_i || lock_to_reference_n_i) begin
			dwell_cnt  <= '0;
			dwell_done <= 1'b0;
		end else if (dwell_cnt == 16'(LOCK_DWELL_CYCLES - 1)) begin
			dwell_done <= 1'b1;
		end else begin
			dwell_cnt <= dwell_cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !supply_good_i) begin
			por_cnt            <= '0;
			power_on_reset_n_o <= 1'b0;
		end else if (por_cnt == 16'(POR_HOLD_CYCLES - 1)) begin
			power_on_reset_n_o <= 1'b1;
		end else begin
			por_cnt <= por_cnt + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	// Ack comes one cycle after the request; writes land on the ack edge.
	assign wb_req = wb_cyc_i && wb_stb_i;
	assign wb_wr  = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];

	function automatic logic [31:0] read_mux(input logic [7:0] adr);
		logic [31:0] v;
		v = '0;
		unique case (adr)
			ADR_CTRL: begin
				v[CTRL_RX_EN_BIT] = rx_enable;
			end
			ADR_STATUS: begin
				v[ST_ALIGNED]    = aligned;
				v[ST_LOSS]       = signal_loss_a_o;
				v[ST_PLL_REF]    = pll_ref_select_o;
				v[ST_DWELL_DONE] = dwell_done;
				v[ST_POR_N]      = power_on_reset_n_o;
				v[ST_LOOPBACK]   = loopback_select_i;
				v[ST_EQ_ON]      = equalizer_active_o;
			end
			ADR_IRQ_STAT: begin
				v[IRQ_W-1:0] = irq_stat;
			end
			ADR_IRQ_MASK: begin
				v[IRQ_W-1:0] = irq_mask;
			end
			ADR_RX_WORD: begin
				v[WORD_W-1:0] = rx_data_o;
			end
			default: begin
				v = '0;
			end
		endcase
		return v;
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req && !wb_ack_o;
			wb_dat_o <= read_mux(wb_adr_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_enable <= CTRL_RX_EN_RST;
			irq_mask  <= IRQ_MASK_RST;
		end else if (wb_wr) begin
			if (wb_adr_i == ADR_CTRL) begin
				rx_enable <= wb_dat_i[CTRL_RX_EN_BIT];
			end
			if (wb_adr_i == ADR_IRQ_MASK) begin
				irq_mask <= wb_dat_i[IRQ_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status
	// ----------------------------------------------------------------
	// A new event in the clearing cycle survives: set beats clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= '0;
		end else begin
			for (int i = 0; i < IRQ_W; i++) begin
				logic ev;
				ev = 1'b0;
				unique case (i)
					IRQ_COMMA:    ev = comma_found_out_o;
					IRQ_LOSS_SET: ev = signal_loss_a_o && !loss_prev;
					IRQ_LOSS_CLR: ev = !signal_loss_a_o && loss_prev;
					IRQ_WORD:     ev = dif.word_valid;
					default:      ev = 1'b0;
				endcase
				if (ev) begin
					irq_stat[i] <= 1'b1;
				end else if (wb_wr && wb_adr_i == ADR_IRQ_STAT && wb_dat_i[i]) begin
					irq_stat[i] <= 1'b0;
				end
			end
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_comma_gated: assert property (@(posedge clk_i) disable iff (rst_i)
		comma_found_out_o |-> $past(comma_align_enable_i) && $past(lock_to_reference_n_i))
		else $error("Comma flag rose while detection was disabled.");

	chk_ref_mode_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!lock_to_reference_n_i [*2] |-> !comma_found_out_o && !dif.comma_hit)
		else $error("Comma seen during reference lock.");

	chk_pll_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(lock_to_reference_n_i) |=> pll_ref_select_o)
		else $error("PLL was not steered to the reference.");

	chk_src_select: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> sel_bit == ($past(loopback_select_i) ? $past(wrap_serial_in_i)
		                                                       : $past(cable_serial_in_i)))
		else $error("Serial source does not follow loopback select.");

	chk_eq_enable: assert property (@(posedge clk_i) disable iff (rst_i)
		(!equalizer_on_n_i && !loopback_select_i) |=> equalizer_active_o)
		else $error("Equalizer not enabled.");

	chk_loss_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		(quiet_edges == LOSS_REF_EDGES) |=> signal_loss_a_o && signal_loss_b_o)
		else $error("Loss not flagged after four quiet reference cycles.");

	chk_loss_amp: assert property (@(posedge clk_i) disable iff (rst_i)
		(amplitude_low_i && !rst_i) |=> signal_loss_a_o && signal_loss_b_o)
		else $error("Loss not flagged on low amplitude.");

	chk_por_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!supply_good_i |=> !power_on_reset_n_o)
		else $error("Power-on reset released without good supply.");

	chk_byte_phase: assert property (@(posedge clk_i) disable iff (rst_i)
		recovered_byte_clocks_o[0] != recovered_byte_clocks_o[1])
		else $error("Byte clocks are not in opposite phase.");

	chk_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Bus ack not a single cycle after request.");

	chk_loss_pair: assert property (@(posedge clk_i) disable iff (rst_i)
		signal_loss_a_o == signal_loss_b_o)
		else $error("Loss outputs disagree.");

	chk_word_lands: assert property (@(posedge clk_i) disable iff (rst_i)
		dif.word_valid |=> rx_data_o == $past(dif.word))
		else $error("Assembled word did not reach the parallel output.");

	chk_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(signal_loss_a_o) |=> irq_stat[IRQ_LOSS_SET])
		else $error("Loss event was not latched in the status.");

	chk_pll_release: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(lock_to_reference_n_i) |=> !pll_ref_select_o)
		else $error("PLL stayed on the reference after release.");

endmodule

// >>> testbench/fcrx_link_partner.sv
// Purpose: Remote serial transmitter and host reference clock for the receive block.
// Assumes: One serial bit per clk_i; a pattern goes out earliest bit first.
// Notes:   Idle line toggles every cycle unless quiet_i holds it still.
`timescale 1ns/1ps
module fcrx_link_partner (
	// Clock
	input  wire logic        clk_i,
	// Requests from the bench
	input  wire logic        go_i,
	input  wire logic [29:0] pat_i,
	input  wire logic [4:0]  len_i,
	input  wire logic        quiet_i,
	// Line and reference
	output logic             line_o,
	output logic             ref_clk_o
);
	logic [29:0] sh = '0;
	logic [4:0]  left = '0;
	logic [1:0]  div = '0;

	// The reference is scaled down so that clk_i can still see its edges.
	assign ref_clk_o = div[1];

	always @(posedge clk_i) begin
		div <= div + 2'h1;
		if (go_i) begin
			sh   <= pat_i;
			left <= len_i;
		end else if (left != 5'h00) begin
			sh   <= sh >> 1;
			left <= left - 5'h01;
		end
		// An idle line holds a stale level only while quiet_i is high, so loss is only seen on purpose.
		if (!go_i && left != 5'h00) begin
			line_o <= sh[0];
		end else if (!quiet_i) begin
			line_o <= ~line_o;
		end
	end

	initial line_o = 1'b0;
endmodule

// >>> testbench/fcrx_top_tb.sv
// Purpose: Self-checking bench for the receive comma-lock control block.
// Assumes: Wishbone slave acks one cycle after a request is taken.
// Notes:   Counts are shortened through the top parameters.
`timescale 1ns/1ps
module fcrx_top_tb;
	import fcrx_pkg::*;
	localparam int         POR_N = 8;
	localparam int         DWELL = 20;
	localparam logic [9:0] COMMA = 10'h17C;
	localparam logic [9:0] BYTE1 = 10'h2A5;
	localparam logic [4:0] CASES [5] = '{5'b00111, 5'b11111, 5'b01110, 5'b00010, 5'b00100};

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        loop_sel = 1'b0;
	logic        eq_n = 1'b1;
	logic        lock_n = 1'b1;
	logic        align_en = 1'b0;
	logic        amp_low = 1'b0;
	logic        supply = 1'b0;
	logic        to_wrap = 1'b0;
	logic        quiet = 1'b0;
	logic        tx_go = 1'b0;
	logic [29:0] tx_pat = '0;
	logic [4:0]  tx_len = '0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = '0;
	logic [31:0] wdat = '0;
	logic [3:0]  sel = '0;
	logic        src;
	logic        ref_clk;
	logic [19:0] rx_data;
	logic [1:0]  bclk;
	logic        comma, loss_a, loss_b, por_n, pll_ref, eq_act, wb_ack, irq;
	logic [31:0] wb_dat;
	logic [31:0] q;
	int          bad_count = 0;
	int          comparisons = 0;
	int          commas = 0;
	int          cycles = 0;
	int          c0;
	int          highs;

	fcrx_link_partner i_fcrx_link_partner (.clk_i(clk_i), .go_i(tx_go), .pat_i(tx_pat),
		.len_i(tx_len), .quiet_i(quiet), .line_o(src), .ref_clk_o(ref_clk));

	fcrx_top #(.LOCK_DWELL_CYCLES(DWELL), .POR_HOLD_CYCLES(POR_N)) i_fcrx_top (
		.clk_i(clk_i), .rst_i(rst_i),
		.cable_serial_in_i(to_wrap ? ~src : src), .wrap_serial_in_i(to_wrap ? src : ~src),
		.loopback_select_i(loop_sel), .equalizer_on_n_i(eq_n), .lock_to_reference_n_i(lock_n),
		.comma_align_enable_i(align_en), .receive_reference_clock_i(ref_clk),
		.amplitude_low_i(amp_low), .supply_good_i(supply), .rx_data_o(rx_data),
		.recovered_byte_clocks_o(bclk), .comma_found_out_o(comma), .signal_loss_a_o(loss_a),
		.signal_loss_b_o(loss_b), .power_on_reset_n_o(por_n), .pll_ref_select_o(pll_ref),
		.equalizer_active_o(eq_act), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
		.irq_o(irq));

	// ----------------------------------------------------------------
	// Clock, pulse counting and hang guard
	// ----------------------------------------------------------------
	initial forever #10 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		cycles++;
		if (comma === 1'b1) commas++;
		if (cycles == 20000) begin
			bad_count++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task check(input string name, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task cyc_wait(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// A classic single cycle; the wait has no assumed length, only a guard.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 16);
		q = wb_dat;
		if (n >= 16) check("wb_ack", 32'(wb_ack), 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task send(input logic [29:0] p, input logic [4:0] n);
		@(posedge clk_i);
		tx_pat <= p;
		tx_len <= n;
		tx_go <= 1'b1;
		@(posedge clk_i);
		tx_go <= 1'b0;
	endtask

	task wait_loss(input logic lvl);
		int n;
		n = 0;
		while (loss_a !== lvl && n < 40) begin
			@(posedge clk_i);
			n++;
		end
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		cyc_wait(8);
		rst_i <= 1'b0;
		cyc_wait(1);
		check("rx_data", 32'(rx_data), 32'h0);
		check("byte_clks", 32'(bclk), 32'h1);
		wb(1'b0, ADR_CTRL, 32'h0);
		check("ctrl", q, 32'(CTRL_RX_EN_RST));
		wb(1'b0, ADR_IRQ_MASK, 32'h0);
		check("irq_mask", q, 32'(IRQ_MASK_RST));
		wb(1'b0, 8'h20, 32'h0);
		check("unmapped", q, 32'h0);
		check("por_n", 32'(por_n), 32'h0);
		supply <= 1'b1;
		cyc_wait(POR_N + 3);
		check("por_n", 32'(por_n), 32'h1);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			loop_sel <= i[0];
			eq_n <= i[1];
			cyc_wait(3);
			check("eq_active", 32'(eq_act), 32'(!i[1] && !i[0]));
		end
		$display("test pins done");
		for (int i = 0; i < 5; i++) begin
			loop_sel <= CASES[i][4];
			to_wrap <= CASES[i][3];
			align_en <= CASES[i][2];
			lock_n <= CASES[i][1];
			cyc_wait(3);
			check("pll_ref", 32'(pll_ref), 32'(!CASES[i][1]));
			c0 = commas;
			send({10'h000, BYTE1, COMMA}, 5'h14);
			cyc_wait(DWELL + 20);
			check("commas", 32'(commas - c0), 32'(CASES[i][0]));
			if (CASES[i][0]) begin
				check("rx_word", 32'(rx_data), 32'({BYTE1, COMMA}));
			end
			if (!CASES[i][1]) begin
				wb(1'b0, ADR_STATUS, 32'h0);
				check("dwell", 32'(q[ST_DWELL_DONE]), 32'h1);
			end
		end
		lock_n <= 1'b1;
		loop_sel <= 1'b0;
		to_wrap <= 1'b0;
		align_en <= 1'b1;
		send({10'h000, BYTE1, COMMA}, 5'h14);
		cyc_wait(24);
		highs = 0;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_i);
			highs += bclk[0];
			check("byte_clk_pair", 32'(bclk[1]), 32'(!bclk[0]));
		end
		check("byte_clk_duty", 32'(highs), 32'(BYTE_W));
		$display("test comma done");
		wb(1'b1, ADR_IRQ_STAT, 32'hF);
		quiet <= 1'b1;
		cyc_wait(8);
		check("loss_early", 32'(loss_a), 32'h0);
		wait_loss(1'b1);
		check("loss_a", 32'(loss_a), 32'h1);
		check("loss_b", 32'(loss_b), 32'h1);
		wb(1'b0, ADR_IRQ_STAT, 32'h0);
		check("irq_loss", 32'(q[IRQ_LOSS_SET]), 32'h1);
		check("irq_masked", 32'(irq), 32'h0);
		wb(1'b1, ADR_IRQ_MASK, 32'h1 << IRQ_LOSS_SET);
		cyc_wait(1);
		check("irq_on", 32'(irq), 32'h1);
		wb(1'b1, ADR_IRQ_STAT, 32'h1 << IRQ_LOSS_SET);
		cyc_wait(1);
		check("irq_clear", 32'(irq), 32'h0);
		wb(1'b1, ADR_IRQ_MASK, 32'h0);
		quiet <= 1'b0;
		wait_loss(1'b0);
		check("loss_gone", 32'(loss_b), 32'h0);
		amp_low <= 1'b1;
		cyc_wait(3);
		check("loss_amp", 32'(loss_b), 32'h1);
		amp_low <= 1'b0;
		$display("test loss done");
		print_verdict();
	end
endmodule
